// file: rtl/kbenc_defs.svh
// Constants of the keyboard encoder: register map, fields, timing
// Operation
// - every code is one 8-bit word
// - alphanumeric keys give codes 000 to 177
// - function keys give codes 200 to 377
// - numeric pad equals alphanumeric digits, shift-independent
// - cursor keys have two codes via control
// - control passes only 000-040, 177, 200-377
// - shift never suppresses, only selects codes
// - shift affects alphanumeric section only
// - compat mode lowers 140-176 by 40
// - compat mode touches alphanumeric codes only
// - key held over one second repeats
// - repeat rate is ten per second
// - only first struck key repeats
// - repeat delay and rate are fixed
// - scan halts until recognised key released
// - on release, next held key is found
// - one code per scan, first key met
// - code 007 drives attention one second, retriggerable
// - host sets sixteen status lights by byte
// - baud, parity and stop bits selectable
`ifndef KBENC_DEFS_SVH
`define KBENC_DEFS_SVH
`define KB_CLK_KHZ         100000
`define KB_REPEAT_DELAY_MS 1000
`define KB_REPEAT_RATE_HZ  10
`define KB_BELL_MS         1000
`define KB_SETTLE_CYC      4'h6
`define KB_REG_CTRL        12'h000
`define KB_REG_BAUD        12'h004
`define KB_REG_STATUS      12'h008
`define KB_REG_LIGHTS      12'h00C
`define KB_CTRL_ONLINE     0
`define KB_CTRL_UCASE      1
`define KB_CTRL_NUMPAD     2
`define KB_CTRL_PAR_LO     3
`define KB_CTRL_PAR_HI     4
`define KB_CTRL_STOP2      5
`define KB_CTRL_RESET      6'h05
`define KB_BAUD_RESET      24'h0028B1
`define KB_STAT_RXERR      11
`define KB_BELL_CODE       8'h07
`define KB_LIGHT_CMD_BIT   7
`define KB_LIGHT_ON_BIT    4
`define KB_PIN_SHIFT       16
`define KB_PIN_LOCK        17
`define KB_PIN_CTRL        18
`endif

// file: rtl/kbenc_pkg.sv
// Types of the keyboard encoder
package kbenc_pkg;
    typedef enum logic [1:0] {SCAN_SETTLE, SCAN_TEST, SCAN_HOLD} kbenc_scan_t;
    typedef struct packed {
        logic [18:0] pinS1;
        logic [18:0] pinS2;
        logic [18:0] pinS3;
        logic [18:0] pinF;
        kbenc_scan_t scan;
        logic [6:0]  idx;
        logic [3:0]  settle;
        logic [7:0]  rowN;
        logic [26:0] rptCnt;
        logic        rptOn;
        logic        pend;
        logic [7:0]  code;
        logic [7:0]  lastCode;
        logic        ack;
        logic        slverr;
        logic [31:0] rdata;
        logic [5:0]  ctrl;
        logic [23:0] baud;
        logic [15:0] lights;
        logic [26:0] bellCnt;
        logic        attn;
        logic        rxErr;
    } kbenc_main_t;
    typedef struct packed {
        logic        txOn;
        logic        txLine;
        logic [10:0] txSh;
        logic [3:0]  txLeft;
        logic [23:0] txCnt;
        logic        rS1;
        logic        rS2;
        logic        rS3;
        logic        rF;
        logic        rxOn;
        logic [3:0]  rxLeft;
        logic [23:0] rxCnt;
        logic [10:0] rxSh;
        logic [7:0]  rxData;
        logic        rxValid;
        logic        rxErr;
    } kbenc_ser_t;
endpackage

// file: rtl/kbenc_ser_if.sv
// Byte channel between the encoder core and its serial port
`timescale 1ns/1ps
`default_nettype none
interface kbenc_ser_if;
    logic [7:0]  txData;
    logic        txValid;
    logic        txReady;
    logic [7:0]  rxData;
    logic        rxValid;
    logic        rxErr;
    logic [23:0] divisor;
    logic [1:0]  parity;
    logic        stop2;
    modport core (output txData, txValid, divisor, parity, stop2,
                  input txReady, rxData, rxValid, rxErr);
    modport port (input txData, txValid, divisor, parity, stop2,
                  output txReady, rxData, rxValid, rxErr);
endinterface
`default_nettype wire

// file: rtl/kbenc_serial.sv
// Asynchronous serial transmitter and receiver of the keyboard
`timescale 1ns/1ps
`default_nettype none
module kbenc_serial (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    kbenc_ser_if.port        ser,
    input  wire logic        serRx,
    output logic             serTx
);
    localparam kbenc_pkg::kbenc_ser_t RST = '{txLine: 1'b1, rS1: 1'b1, rS2: 1'b1,
                                             rS3: 1'b1, rF: 1'b1, default: '0};
    kbenc_pkg::kbenc_ser_t st_ff;
    kbenc_pkg::kbenc_ser_t nxt_st;
    logic                  hasPar;

    // Mode 1 is odd parity, mode 2 even, others none
    function automatic logic parOf(input logic [7:0] d, input logic [1:0] m);
        parOf = (m == 2'h1) ? ~^d : ^d;
    endfunction

    assign hasPar      = ^ser.parity;
    assign ser.txReady = ~st_ff.txOn;
    assign ser.rxData  = st_ff.rxData;
    assign ser.rxValid = st_ff.rxValid;
    assign ser.rxErr   = st_ff.rxErr;
    assign serTx       = st_ff.txLine;

    always_comb
    begin
        logic [10:0] v;
        v              = {st_ff.rF, st_ff.rxSh[10:1]};
        nxt_st         = st_ff;
        nxt_st.rxValid = 1'b0;
        nxt_st.rxErr   = 1'b0;
        nxt_st.rS1     = serRx;
        nxt_st.rS2     = st_ff.rS1;
        nxt_st.rS3     = st_ff.rS2;
        nxt_st.rF      = (st_ff.rS2 & st_ff.rS3) | (st_ff.rF & (st_ff.rS2 ^ st_ff.rS3));
        if (!st_ff.txOn)
        begin
            if (ser.txValid)
            begin
                nxt_st.txOn   = 1'b1;
                nxt_st.txLine = 1'b0;
                nxt_st.txSh   = {2'h3, hasPar ? parOf(ser.txData, ser.parity) : 1'b1,
                                 ser.txData};
                nxt_st.txLeft = 4'h9 + {3'h0, hasPar} + {3'h0, ser.stop2};
                nxt_st.txCnt  = ser.divisor - 24'h000001;
            end
        end
        else if (st_ff.txCnt != 24'h000000)
            nxt_st.txCnt = st_ff.txCnt - 24'h000001;
        else if (st_ff.txLeft == 4'h0)
            nxt_st.txOn = 1'b0;
        else
        begin
            nxt_st.txLine = st_ff.txSh[0];
            nxt_st.txSh   = {1'b1, st_ff.txSh[10:1]};
            nxt_st.txLeft = st_ff.txLeft - 4'h1;
            nxt_st.txCnt  = ser.divisor - 24'h000001;
        end
        if (!st_ff.rxOn)
        begin
            if (st_ff.rF && !st_ff.rS2 && !st_ff.rS3)
            begin
                nxt_st.rxOn   = 1'b1;
                nxt_st.rxCnt  = {1'b0, ser.divisor[23:1]};
                nxt_st.rxLeft = 4'hA + {3'h0, hasPar};
            end
        end
        else if (st_ff.rxCnt != 24'h000000)
            nxt_st.rxCnt = st_ff.rxCnt - 24'h000001;
        else
        begin
            nxt_st.rxSh   = v;
            nxt_st.rxCnt  = ser.divisor - 24'h000001;
            nxt_st.rxLeft = st_ff.rxLeft - 4'h1;
            if (st_ff.rxLeft == 4'h1)
            begin
                nxt_st.rxOn    = 1'b0;
                nxt_st.rxData  = hasPar ? v[8:1] : v[9:2];
                nxt_st.rxErr   = ~v[10] | (hasPar & (v[9] != parOf(v[8:1], ser.parity)));
                nxt_st.rxValid = ~nxt_st.rxErr;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= RST;
        else
            st_ff <= nxt_st;
    end
endmodule // kbenc_serial
`default_nettype wire

// file: rtl/kbenc_top.sv
// Keyboard encoder: matrix scan, code mapping, repeat, serial, APB registers
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "kbenc_defs.svh"
module kbenc_top #(
    parameter int REPEAT_DELAY_CYC  = `KB_REPEAT_DELAY_MS * (`KB_CLK_KHZ),
    parameter int REPEAT_PERIOD_CYC = ((`KB_CLK_KHZ) * 1000) / `KB_REPEAT_RATE_HZ,
    parameter int BELL_CYC          = `KB_BELL_MS * (`KB_CLK_KHZ)
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  rowDriveN,
    input  wire logic [15:0] colSenseN,
    input  wire logic        shiftKeyN,
    input  wire logic        shiftLockN,
    input  wire logic        ctrlKeyN,
    output logic             serTx,
    input  wire logic        serRx,
    output logic             attention,
    output logic      [15:0] statusLights
);
    localparam kbenc_pkg::kbenc_main_t RST = '{
        pinS1:  '1,
        pinS2:  '1,
        pinS3:  '1,
        pinF:   '1,
        scan:   kbenc_pkg::SCAN_SETTLE,
        settle: `KB_SETTLE_CYC,
        rowN:   8'hFE,
        ctrl:   `KB_CTRL_RESET,
        baud:   `KB_BAUD_RESET,
        default: '0
    };

    kbenc_pkg::kbenc_main_t st_ff;
    kbenc_pkg::kbenc_main_t nxt_st;
    kbenc_ser_if            ser ();

    logic       shiftOn;
    logic       ctrlOn;
    logic       keyDown;
    logic [8:0] kc;
    logic       setupCyc;
    logic       writeCyc;
    logic       fire;

    // Row strobe for a key index; one row low at a time
    function automatic logic [7:0] rowSel(input logic [6:0] k);
        rowSel = ~(8'h01 << k[6:4]);
    endfunction

    // Code for a key position: bit 8 says a code is sent at all.
    // 00-1F letter block, 20-3F digit/punct block, 40-4B numeric pad,
    // 4C-57 cursor pad, 58-67 special keys, the rest unfitted.
    function automatic logic [8:0] keyCode(
        input logic [6:0] k,
        input logic       sh,
        input logic       ctl,
        input logic       uc,
        input logic       np
    );
        logic [7:0] c;
        logic [6:0] n;
        logic       ok;
        c  = 8'h00;
        ok = 1'b1;
        n  = 7'h00;
        if (k < 7'h20)
        begin
            if (ctl)
                c = {3'h0, k[4:0]};
            else
                c = sh ? {3'h2, k[4:0]} : {3'h3, k[4:0]};
        end
        else if (k < 7'h40)
            c = {3'h1, k[4] ^ sh, k[3:0]};
        else if (k < 7'h4C)
        begin
            n = k - 7'h40;
            if (!np)
                c = {3'h4, n[3:0], ctl};
            else if (n < 7'h0A)
                c = {4'h3, n[3:0]};
            else
                c = (n == 7'h0A) ? 8'h2E : 8'h2C;
        end
        else if (k < 7'h58)
        begin
            n = k - 7'h4C;
            c = {3'h5, n[3:0], ctl};
        end
        else if (k < 7'h68)
        begin
            n = k - 7'h58;
            c = {3'h6, n[3:0], ctl};
        end
        else
            ok = 1'b0;
        if (uc && k < 7'h40 && c >= 8'h60 && c <= 8'h7E)
            c = c - 8'h20;
        if (ctl && !(c <= 8'h20 || c == 8'h7F || c[7]))
            ok = 1'b0;
        keyCode = {ok, c};
    endfunction

    assign shiftOn  = ~st_ff.pinF[`KB_PIN_SHIFT] | ~st_ff.pinF[`KB_PIN_LOCK];
    assign ctrlOn   = ~st_ff.pinF[`KB_PIN_CTRL];
    assign keyDown  = ~st_ff.pinF[st_ff.idx[3:0]];
    assign kc       = keyCode(st_ff.idx, shiftOn, ctrlOn,
                              st_ff.ctrl[`KB_CTRL_UCASE], st_ff.ctrl[`KB_CTRL_NUMPAD]);
    assign setupCyc = psel & ~penable;
    assign writeCyc = psel & penable & st_ff.ack & pwrite & ~st_ff.slverr;

    // Repeat delay and rate are elaboration constants only
    assign fire = st_ff.rptOn ? (st_ff.rptCnt == 27'(REPEAT_PERIOD_CYC - 1))
                              : (st_ff.rptCnt == 27'(REPEAT_DELAY_CYC - 1));

    assign ser.txData  = st_ff.code;
    assign ser.txValid = st_ff.pend;
    assign ser.divisor = st_ff.baud;
    assign ser.parity  = st_ff.ctrl[`KB_CTRL_PAR_HI:`KB_CTRL_PAR_LO];
    assign ser.stop2   = st_ff.ctrl[`KB_CTRL_STOP2];

    assign prdata       = st_ff.rdata;
    assign pready       = st_ff.ack;
    assign pslverr      = st_ff.ack & st_ff.slverr;
    assign rowDriveN    = st_ff.rowN;
    assign attention    = st_ff.attn;
    assign statusLights = st_ff.lights;

    kbenc_serial u_serial (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ser      (ser.port),
        .serRx    (serRx),
        .serTx    (serTx)
    );

    always_comb
    begin
        nxt_st = st_ff;

        // Pins: third stage agreeing with second updates the level
        nxt_st.pinS1 = {ctrlKeyN, shiftLockN, shiftKeyN, colSenseN};
        nxt_st.pinS2 = st_ff.pinS1;
        nxt_st.pinS3 = st_ff.pinS2;
        nxt_st.pinF  = (st_ff.pinS2 & st_ff.pinS3)
                     | (st_ff.pinF & (st_ff.pinS2 ^ st_ff.pinS3));

        if (st_ff.pend && ser.txReady)
            nxt_st.pend = 1'b0;

        case (st_ff.scan)
            kbenc_pkg::SCAN_SETTLE:
            begin
                // Columns need the sync delay after a row change
                if (st_ff.settle == 4'h0)
                    nxt_st.scan = kbenc_pkg::SCAN_TEST;
                else
                    nxt_st.settle = st_ff.settle - 4'h1;
            end
            kbenc_pkg::SCAN_TEST:
            begin
                if (keyDown && kc[8])
                begin
                    // A pending code blocks a new one rather than drop it
                    if (!st_ff.pend)
                    begin
                        nxt_st.scan     = kbenc_pkg::SCAN_HOLD;
                        nxt_st.pend     = st_ff.ctrl[`KB_CTRL_ONLINE];
                        nxt_st.code     = kc[7:0];
                        nxt_st.lastCode = kc[7:0];
                        nxt_st.rptCnt   = 27'h0000000;
                        nxt_st.rptOn    = 1'b0;
                    end
                end
                else
                begin
                    // Scan goes on from its current position
                    nxt_st.idx = st_ff.idx + 7'h01;
                    if (st_ff.idx[3:0] == 4'hF)
                    begin
                        nxt_st.scan   = kbenc_pkg::SCAN_SETTLE;
                        nxt_st.settle = `KB_SETTLE_CYC;
                        nxt_st.rowN   = rowSel(st_ff.idx + 7'h01);
                    end
                end
            end
            kbenc_pkg::SCAN_HOLD:
            begin
                if (!keyDown)
                begin
                    // Resume past the released key so a held one is met
                    nxt_st.idx    = st_ff.idx + 7'h01;
                    nxt_st.scan   = kbenc_pkg::SCAN_SETTLE;
                    nxt_st.settle = `KB_SETTLE_CYC;
                    nxt_st.rowN   = rowSel(st_ff.idx + 7'h01);
                    nxt_st.rptOn  = 1'b0;
                end
                else if (fire)
                begin
                    // Only the locked key repeats; a busy line skips a beat
                    nxt_st.rptCnt = 27'h0000000;
                    nxt_st.rptOn  = 1'b1;
                    if (!st_ff.pend && st_ff.ctrl[`KB_CTRL_ONLINE])
                        nxt_st.pend = 1'b1;
                end
                else
                    nxt_st.rptCnt = st_ff.rptCnt + 27'h0000001;
            end
            default:
            begin
                nxt_st.scan   = kbenc_pkg::SCAN_SETTLE;
                nxt_st.settle = `KB_SETTLE_CYC;
            end
        endcase

        // Attention output, retriggered by every bell byte
        if (ser.rxValid && ser.rxData == `KB_BELL_CODE)
            nxt_st.bellCnt = 27'(BELL_CYC);
        else if (st_ff.bellCnt != 27'h0000000)
            nxt_st.bellCnt = st_ff.bellCnt - 27'h0000001;
        nxt_st.attn = (nxt_st.bellCnt != 27'h0000000);

        // Light byte: top bit set, bit 4 on/off, bits 3:0 index
        if (ser.rxValid && ser.rxData[`KB_LIGHT_CMD_BIT])
            nxt_st.lights[ser.rxData[3:0]] = ser.rxData[`KB_LIGHT_ON_BIT];

        // APB: registered answer one cycle after setup, no wait state
        nxt_st.ack = setupCyc;
        if (setupCyc)
        begin
            nxt_st.slverr = 1'b0;
            case (paddr)
                `KB_REG_CTRL:   nxt_st.rdata = {26'h0000000, st_ff.ctrl};
                `KB_REG_BAUD:   nxt_st.rdata = {8'h00, st_ff.baud};
                `KB_REG_STATUS: nxt_st.rdata = {20'h00000, st_ff.rxErr,
                                                st_ff.pend | ~ser.txReady, st_ff.attn,
                                                st_ff.scan == kbenc_pkg::SCAN_HOLD,
                                                st_ff.lastCode};
                `KB_REG_LIGHTS: nxt_st.rdata = {16'h0000, st_ff.lights};
                default:
                begin
                    nxt_st.rdata  = 32'h00000000;
                    nxt_st.slverr = 1'b1;
                end
            endcase
        end
        if (writeCyc)
        begin
            case (paddr)
                `KB_REG_CTRL:   nxt_st.ctrl = pwdata[5:0];
                `KB_REG_BAUD:   nxt_st.baud = pwdata[23:0];
                `KB_REG_STATUS:
                begin
                    if (pwdata[`KB_STAT_RXERR])
                        nxt_st.rxErr = 1'b0;
                end
                default:        nxt_st.rxErr = nxt_st.rxErr;
            endcase
        end
        // A framing or parity fault sets the flag even during its clear
        if (ser.rxErr)
            nxt_st.rxErr = 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= RST;
        else
            st_ff <= nxt_st;
    end
endmodule // kbenc_top
`default_nettype wire

// file: tb/kbenc_link_model.sv
// Far-end serial link: frame receiver and byte sender
`timescale 1ns/1ps
`default_nettype none
module kbenc_link_model (
    input  wire logic core_clk,
    input  wire logic serTx,
    output logic      serRx
);
    int         bitCyc = 16;
    logic [1:0] par = 2'h0;
    logic       st2 = 1'b0;
    logic [7:0] rxQ[$];
    int         frameErr = 0;
    logic [7:0] d;
    function automatic logic pbit(input logic [7:0] v);
        return (par == 2'h1) ? ~^v : ^v;
    endfunction
    initial
    begin
        serRx = 1'b1;
        forever
        begin
            @(negedge serTx);
            repeat (bitCyc / 2) @(posedge core_clk);
            if (serTx !== 1'b0) frameErr++;
            for (int i = 0; i < 8; i++)
            begin
                repeat (bitCyc) @(posedge core_clk);
                d[i] = serTx;
            end
            if (par == 2'h1 || par == 2'h2)
            begin
                repeat (bitCyc) @(posedge core_clk);
                if (serTx !== pbit(d)) frameErr++;
            end
            repeat (st2 ? 2 : 1)
            begin
                repeat (bitCyc) @(posedge core_clk);
                if (serTx !== 1'b1) frameErr++;
            end
            rxQ.push_back(d);
        end
    end
    // A bad parity bit is sent only when a test asks for a refused byte
    task automatic send(input logic [7:0] v, input logic badPar);
        @(posedge core_clk);
        serRx <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            repeat (bitCyc) @(posedge core_clk);
            serRx <= v[i];
        end
        if (par == 2'h1 || par == 2'h2)
        begin
            repeat (bitCyc) @(posedge core_clk);
            serRx <= pbit(v) ^ badPar;
        end
        repeat (bitCyc) @(posedge core_clk);
        serRx <= 1'b1;
        repeat (st2 ? 2 * bitCyc : bitCyc) @(posedge core_clk);
    endtask
endmodule // kbenc_link_model
`default_nettype wire

// file: tb/kbenc_top_asserts.sv
// Port checks of the keyboard encoder
`timescale 1ns/1ps
`default_nettype none
module kbenc_top_asserts (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  rowDriveN,
    input wire logic [15:0] colSenseN,
    input wire logic        shiftKeyN,
    input wire logic        shiftLockN,
    input wire logic        ctrlKeyN,
    input wire logic        serTx,
    input wire logic        serRx,
    input wire logic        attention,
    input wire logic [15:0] statusLights
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence setupS;
        psel && !penable;
    endsequence
    sequence unmapS;
        setupS ##0 (paddr > 12'h00C);
    endsequence
    apb_answer_a: assert property (setupS |=> pready) else $error("no ready");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("stray ready");
    ready_once_a: assert property (pready |=> !pready) else $error("long ready");
    err_unmap_a: assert property (unmapS |=> pslverr && prdata == 32'h0)
        else $error("no error");
    err_only_a: assert property (pslverr |-> pready
        && !($past(paddr) inside {12'h000, 12'h004, 12'h008, 12'h00C}))
        else $error("stray error");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved");
    row_onehot_a: assert property ($onehot(~rowDriveN)) else $error("row strobe");
    row_settle_a: assert property ($changed(rowDriveN) |=> $stable(rowDriveN) [*6])
        else $error("row too short");
    light_one_a: assert property ($changed(statusLights)
        |-> $countones(statusLights ^ $past(statusLights)) == 1) else $error("lights");
    light_ro_a: assert property (psel && penable && pwrite && paddr == 12'h00C
        |=> $stable(statusLights)) else $error("lights written");
    attn_min_a: assert property ($rose(attention) |=> attention [*8])
        else $error("attention short");
    cover property ($rose(attention));
endmodule // kbenc_top_asserts
bind kbenc_top kbenc_top_asserts u_chk (.core_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rowDriveN, .colSenseN, .shiftKeyN,
    .shiftLockN, .ctrlKeyN, .serTx, .serRx, .attention, .statusLights);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the keyboard encoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int DLY = 1000;
    localparam int PER = 400;
    localparam int BELL = 300;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] rowDriveN;
    logic [15:0] colSenseN, statusLights;
    logic shiftKeyN, shiftLockN, ctrlKeyN, serTx, serRx, attention;
    logic [127:0] keys;
    int mismatches, num_checks, c, k, sh, ct, uc, np, n, bad, lights;
    kbenc_top #(.REPEAT_DELAY_CYC(DLY), .REPEAT_PERIOD_CYC(PER), .BELL_CYC(BELL))
        u_kbenc_top (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rowDriveN, .colSenseN, .shiftKeyN, .shiftLockN,
        .ctrlKeyN, .serTx, .serRx, .attention, .statusLights);
    kbenc_link_model lnk (.core_clk, .serTx, .serRx);
    always_comb
    begin
        colSenseN = 16'hFFFF;
        for (int r = 0; r < 8; r++)
            if (!rowDriveN[r]) colSenseN &= ~keys[r*16 +: 16];
    end
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic getCode(input int lim);
        c = -1;
        for (int i = 0; i < lim && c < 0; i++)
        begin
            @(posedge core_clk);
            if (lnk.rxQ.size() > 0) c = lnk.rxQ.pop_front();
        end
    endtask
    task automatic tick(input int t);
        repeat (t) @(posedge core_clk);
    endtask
    // Reference key map; -1 means the key sends nothing
    function automatic int expCode(int k, int sh, int ct, int uc, int np);
        int v;
        if (k < 32) v = ct ? k : (sh ? 64 + k : 96 + k);
        else if (k < 64) v = (32 + k % 32) ^ (sh ? 16 : 0);
        else if (k < 76) v = np ? (k < 74 ? k - 16 : (k == 74 ? 46 : 44))
            : 128 + 2 * (k - 64) + ct;
        else if (k < 88) v = 160 + 2 * (k - 76) + ct;
        else if (k < 104) v = 192 + 2 * (k - 88) + ct;
        else v = -1;
        if (uc && k < 64 && v >= 96 && v <= 126) v -= 32;
        if (ct && v > 32 && v != 127 && v < 128) v = -1;
        return v;
    endfunction
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, keys} = '0;
        {shiftKeyN, shiftLockN, ctrlKeyN} = 3'h7;
        {mismatches, num_checks, lights} = '0;
        void'($urandom(32'hCCDB9396));
        tick(8);
        rst_n <= 1'b1;
        apb(0, 12'h000, 0);
        chk("ctrl", 32'h5, rd);
        apb(0, 12'h004, 0);
        chk("baud", 32'h28B1, rd);
        apb(1, 12'h00C, 32'hFFFF);
        chk("lights_ro", 0, statusLights);
        apb(0, 12'h010, 0);
        chk("unmapped", 1, err);
        apb(1, 12'h004, 16);
        $display("test registers done");
        for (int t = 0; t < 24; t++)
        begin
            k = $urandom % 128;
            {sh, ct, uc, np} = {$urandom % 2, $urandom % 2, $urandom % 2, $urandom % 2};
            lnk.par = 2'(t % 4);
            lnk.st2 = 1'(t / 4 % 2);
            apb(1, 12'h000, 32'(1 + uc * 2 + np * 4 + (t % 4) * 8 + (t / 4 % 2) * 32));
            shiftKeyN <= !(sh && t % 2);
            shiftLockN <= !(sh && !(t % 2));
            ctrlKeyN <= !ct;
            tick(5);
            keys[k] <= 1'b1;
            getCode(500);
            chk("code", expCode(k, sh, ct, uc, np), c);
            keys[k] <= 1'b0;
            tick(30);
        end
        chk("framing", 0, lnk.frameErr);
        $display("test codes done");
        {lnk.par, lnk.st2} = '0;
        apb(1, 12'h000, 32'h5);
        {shiftKeyN, shiftLockN, ctrlKeyN} <= 3'h7;
        tick(5);
        keys[65] <= 1'b1;
        getCode(400);
        chk("first", 49, c);
        keys[76] <= 1'b1;
        getCode(300);
        chk("locked", -1, c);
        keys[65] <= 1'b0;
        getCode(400);
        chk("rollover", 160, c);
        keys[16] <= 1'b1;
        {n, bad} = '0;
        for (int i = 0; i < DLY + 2 * PER + 100; i++)
        begin
            @(posedge core_clk);
            if (lnk.rxQ.size() > 0)
            begin
                n++;
                if (lnk.rxQ.pop_front() !== 8'hA0) bad++;
            end
        end
        chk("repeats", 3, n);
        chk("only_first", 0, bad);
        keys[76] <= 1'b0;
        keys[16] <= 1'b0;
        tick(400);
        lnk.rxQ.delete();
        $display("test lockout done");
        lnk.send(8'h07, 1'b0);
        tick(20);
        chk("attn", 1, attention);
        tick(60);
        lnk.send(8'h07, 1'b0);
        tick(BELL - 40);
        chk("attn_hold", 1, attention);
        tick(80);
        chk("attn_end", 0, attention);
        $display("test bell done");
        for (int t = 0; t < 8; t++)
        begin
            k = $urandom % 16;
            n = (t < 4) ? 1 : $urandom % 2;
            lnk.send(8'(128 + n * 16 + k), 1'b0);
            lights = n ? lights | (1 << k) : lights & ~(1 << k);
            tick(10);
            chk("light", lights, statusLights);
        end
        lnk.send(8'h41, 1'b0);
        tick(10);
        chk("ignored", lights, statusLights);
        apb(0, 12'h00C, 0);
        chk("light_reg", lights, rd);
        apb(1, 12'h000, 32'hD);
        lnk.par = 2'h1;
        lnk.send(8'h9F, 1'b1);
        tick(10);
        apb(0, 12'h008, 0);
        chk("rx_err", 1, rd[11]);
        chk("status", 32'h8A0, rd);
        chk("dropped", lights, statusLights);
        apb(1, 12'h008, 32'h800);
        apb(0, 12'h008, 0);
        chk("err_clear", 0, rd[11]);
        $display("test host bytes done");
        end_sim();
    end
    initial
    begin
        tick(40000);
        mismatches++;
        end_sim();
    end
endmodule // testbench
`default_nettype wire
